// ===== orx_cfg.svh
// Summary of operation
// - Null instruction CC 00 changes no register, memory word or flag.
// - Word and byte OR write destination OR source back into the destination.
// - OR flags: E from source lowest negative, Z result zero, V C cleared, N top.
// - Word OR forms: 78 short immediate, indirect, post-increment; 70; 74, 76, 72.
// - Byte OR forms: 79 short, 71 register pairs, 75, 77 immediate byte, 73.
// - Push-call pushes operand, pushes next pointer, then jumps to the target.
// - Push-call is four bytes: E2, register byte, two-byte target address.
// - Push-call and push set E, Z, N from pushed operand; V, C kept.
// - Pop FC reads word at stack pointer, adds two, writes register operand.
// - Pop sets E, Z, N from popped word; V and C kept.
// - Normalize 2B writes left-shift count to top bit one, zero for zero source.
// - Normalize sets Z only for zero source, clears E, V, C and N.
// - Push EC decrements stack pointer by two, then stores register operand.
// - Power-down is recognised only as complete pattern 97 68 97 97.
// - Power-down with NMI low halts until reset; otherwise no effect.
// - Power-down leaves all five flags unchanged.
`ifndef ORX_CFG_SVH
`define ORX_CFG_SVH

// opcodes
`define ORX_OP_NULL       8'hCC
`define ORX_NULL_B1       8'h00
`define ORX_OP_ORW_SHORT  8'h78
`define ORX_OP_ORB_SHORT  8'h79
`define ORX_OP_ORW_RR     8'h70
`define ORX_OP_ORB_RR     8'h71
`define ORX_OP_ORW_REGMEM 8'h72
`define ORX_OP_ORB_REGMEM 8'h73
`define ORX_OP_ORW_MEMREG 8'h74
`define ORX_OP_ORB_MEMREG 8'h75
`define ORX_OP_ORW_IMM    8'h76
`define ORX_OP_ORB_IMM    8'h77
`define ORX_OP_PUSH_AND_CALL_ABSOLUTE      8'hE2
`define ORX_OP_PUSH       8'hEC
`define ORX_OP_POP        8'hFC
`define ORX_OP_NORM       8'h2B
`define ORX_PD_KEY_A      8'h97
`define ORX_PD_KEY_B      8'h68

// sizes and steps
`define ORX_LEN_SHORT     16'h0002
`define ORX_LEN_LONG      16'h0004
`define ORX_STACK_STEP    16'h0002
`define ORX_WORD_STEP     16'h0002
`define ORX_BYTE_STEP     16'h0001
`define ORX_MIN_NEG_W     16'h8000
`define ORX_MIN_NEG_B     8'h80

// flag bit positions
`define ORX_PSW_C         0
`define ORX_PSW_V         1
`define ORX_PSW_Z         2
`define ORX_PSW_N         3
`define ORX_PSW_E         4

// status bit positions
`define ORX_STAT_DOWN     0
`define ORX_STAT_BUSY     1
`define ORX_STAT_ILLEGAL  2

// register word indices (byte address is four times)
`define ORX_IDX_SP        6'h10
`define ORX_IDX_IP        6'h11
`define ORX_IDX_PSW       6'h12
`define ORX_IDX_STAT      6'h13

// reset values
`define ORX_RST_SP        16'h0000
`define ORX_RST_IP        16'h0000
`define ORX_RST_PSW       5'h00

`endif

// ===== orx_pkg.sv
package orx_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SRC_RD,
        ST_DST_WR,
        ST_PUSH_WR,
        ST_CALL_WR,
        ST_POP_RD,
        ST_DOWN
    } orx_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        we;
        logic        byte_acc;
    } orx_mem_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } orx_wb_req_s;

    typedef struct packed {
        orx_state_e        st;
        logic [15:0][15:0] gpr;
        logic [15:0]       stack_pointer;
        logic [15:0]       instruction_pointer;
        logic [4:0]        psw;
        logic [31:0]       ir;
        logic              illegal;
        orx_mem_s          mem;
        logic              mem_req;
        logic              wb_ack;
        logic [31:0]       wb_dat;
    } orx_regs_s;

endpackage

// ===== orx_flag_gen.sv
`timescale 1ns/100ps
`include "orx_cfg.svh"
module orx_flag_gen
    import orx_pkg::*;
#(
    parameter int WIDTH = 16
)(
    // operand
    input  wire logic [WIDTH-1:0] value,
    // flags
    output logic                  min_neg,
    output logic                  zero,
    output logic                  negative
);

    // =========================================================
    // elaboration check
    if (WIDTH < 2)
    begin : g_bad_width
        $error("orx_flag_gen width too small");
    end

    // =========================================================
    // flag terms
    localparam logic [WIDTH-1:0] MIN_NEG = {1'b1, {(WIDTH-1){1'b0}}};

    assign min_neg  = (value == MIN_NEG);
    assign zero     = (value == '0);
    assign negative = value[WIDTH-1];

endmodule // orx_flag_gen

// ===== orx_exec.sv
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "orx_cfg.svh"
module orx_exec
    import orx_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    // register bus
    input  wire orx_wb_req_s wb_req,
    output logic             wb_ack,
    output logic [31:0]      wb_dat_r,
    // instruction fetch
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr_data,
    output logic             instr_ready,
    output logic [15:0]      instruction_pointer,
    // data memory
    output orx_mem_s         mem,
    output logic             mem_req,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    // system
    input  wire logic        nmi_in,
    output logic             power_down,
    output logic [4:0]       psw
);

    // =========================================================
    // state
    orx_regs_s s;
    orx_regs_s next_s;

    logic [31:0] cur;
    logic [7:0]  op, b1, b2, b3, rd_byte;
    logic [3:0]  dst_idx;
    logic [15:0] dst_v, src_v, res_v, rd_v;
    logic [4:0]  or_psw;
    logic        bm, wb_hit, accept, pd_key;
    logic        sw_e, sw_z, sw_n, sb_e, sb_z, sb_n;
    logic        rw_e, rw_z, rw_n, rb_e, rb_z, rb_n;

    // =========================================================
    // helpers
    function automatic logic [15:0] get_reg(logic [15:0][15:0] g, logic [3:0] idx,
                                            logic byte_mode);
        logic [15:0] w;
        w = g[idx[3:1]];
        if (!byte_mode)
            return g[idx];
        return idx[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    endfunction
    function automatic logic [15:0][15:0] put_reg(logic [15:0][15:0] g, logic [3:0] idx,
                                                  logic byte_mode, logic [15:0] v);
        logic [15:0][15:0] r;
        r = g;
        if (!byte_mode)
            r[idx] = v;
        else if (idx[0])
            r[idx[3:1]][15:8] = v[7:0];
        else
            r[idx[3:1]][7:0] = v[7:0];
        return r;
    endfunction
    function automatic logic [15:0] merge16(logic [15:0] old, logic [15:0] d, logic [1:0] sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction
    function automatic logic [15:0] norm_count(logic [15:0] v);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 0; i < 16; i++)
            if (v[i])
                c = 16'(15 - i);
        return c;
    endfunction

    // =========================================================
    // flag generators
    orx_flag_gen #(.WIDTH(16)) u_src_w (.value(src_v),      .min_neg(sw_e), .zero(sw_z),
                                        .negative(sw_n));
    orx_flag_gen #(.WIDTH(8))  u_src_b (.value(src_v[7:0]), .min_neg(sb_e), .zero(sb_z),
                                        .negative(sb_n));
    orx_flag_gen #(.WIDTH(16)) u_res_w (.value(res_v),      .min_neg(rw_e), .zero(rw_z),
                                        .negative(rw_n));
    orx_flag_gen #(.WIDTH(8))  u_res_b (.value(res_v[7:0]), .min_neg(rb_e), .zero(rb_z),
                                        .negative(rb_n));
    assign or_psw = {bm ? sb_e : sw_e, bm ? rb_n : rw_n, bm ? rb_z : rw_z, 2'b00};

    // =========================================================
    // operand selection
    always_comb
    begin
        cur     = (s.st == ST_IDLE) ? instr_data : s.ir;
        op      = cur[7:0];
        b1      = cur[15:8];
        b2      = cur[23:16];
        b3      = cur[31:24];
        bm      = (op[7:4] == 4'h7) && op[0];
        pd_key  = (b1 == `ORX_PD_KEY_B) && (b2 == `ORX_PD_KEY_A) && (b3 == `ORX_PD_KEY_A);
        rd_byte = s.mem.addr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
        rd_v    = bm ? {8'h00, rd_byte} : mem_rdata;
        dst_idx = b1[3:0];
        dst_v   = 16'h0000;
        src_v   = 16'h0000;
        unique case (op)
            `ORX_OP_ORW_SHORT, `ORX_OP_ORB_SHORT:
            begin
                dst_idx = b1[7:4];
                dst_v   = get_reg(s.gpr, b1[7:4], bm);
                src_v   = b1[3] ? rd_v : {13'h0000, b1[2:0]};
            end
            `ORX_OP_ORW_RR, `ORX_OP_ORB_RR:
            begin
                dst_idx = b1[7:4];
                dst_v   = get_reg(s.gpr, b1[7:4], bm);
                src_v   = get_reg(s.gpr, b1[3:0], bm);
            end
            `ORX_OP_ORW_REGMEM, `ORX_OP_ORB_REGMEM:
            begin
                dst_v = get_reg(s.gpr, b1[3:0], bm);
                src_v = rd_v;
            end
            `ORX_OP_ORW_MEMREG, `ORX_OP_ORB_MEMREG:
            begin
                dst_v = rd_v;
                src_v = get_reg(s.gpr, b1[3:0], bm);
            end
            `ORX_OP_ORW_IMM, `ORX_OP_ORB_IMM:
            begin
                dst_v = get_reg(s.gpr, b1[3:0], bm);
                src_v = bm ? {8'h00, b2} : {b3, b2};
            end
            `ORX_OP_PUSH_AND_CALL_ABSOLUTE, `ORX_OP_PUSH, `ORX_OP_NORM:
                src_v = get_reg(s.gpr, b1[3:0], 1'b0);
            `ORX_OP_POP:
                src_v = mem_rdata;
            default:
                src_v = 16'h0000;
        endcase
        res_v = dst_v | src_v;
    end

    // =========================================================
    // next state
    always_comb
    begin
        next_s         = s;
        next_s.wb_ack  = 1'b0;
        wb_hit         = wb_req.cyc && wb_req.stb;
        instr_ready    = (s.st == ST_IDLE) && !wb_hit;
        accept         = instr_ready && instr_valid;
        // register bus
        if (wb_hit && !s.wb_ack && (s.st == ST_IDLE))
        begin
            next_s.wb_ack = 1'b1;
            next_s.wb_dat = 32'h0000_0000;
            if (wb_req.adr[7:6] == 2'b00)
                next_s.wb_dat[15:0] = s.gpr[wb_req.adr[5:2]];
            else
                unique case (wb_req.adr[7:2])
                    `ORX_IDX_SP:   next_s.wb_dat[15:0] = s.stack_pointer;
                    `ORX_IDX_IP:   next_s.wb_dat[15:0] = s.instruction_pointer;
                    `ORX_IDX_PSW:  next_s.wb_dat[4:0]  = s.psw;
                    `ORX_IDX_STAT: next_s.wb_dat[2:0]  = {s.illegal, 1'b0, 1'b0};
                    default:       next_s.wb_dat       = 32'h0000_0000;
                endcase
        end
        if (wb_hit && s.wb_ack && wb_req.we)
        begin
            if (wb_req.adr[7:6] == 2'b00)
                next_s.gpr[wb_req.adr[5:2]] = merge16(s.gpr[wb_req.adr[5:2]],
                                                      wb_req.dat[15:0], wb_req.sel[1:0]);
            else
                unique case (wb_req.adr[7:2])
                    `ORX_IDX_SP:
                        next_s.stack_pointer = merge16(s.stack_pointer, wb_req.dat[15:0],
                                                       wb_req.sel[1:0]);
                    `ORX_IDX_IP:
                        next_s.instruction_pointer = merge16(s.instruction_pointer,
                                                             wb_req.dat[15:0], wb_req.sel[1:0]);
                    `ORX_IDX_PSW:
                        if (wb_req.sel[0])
                            next_s.psw = wb_req.dat[4:0];
                    `ORX_IDX_STAT:
                        if (wb_req.sel[0] && wb_req.dat[`ORX_STAT_ILLEGAL])
                            next_s.illegal = 1'b0;
                    default:
                        next_s.illegal = s.illegal;
                endcase
        end
        // execution
        unique case (s.st)
            ST_IDLE:
            begin
                if (accept)
                begin
                    next_s.ir = instr_data;
                    next_s.instruction_pointer = s.instruction_pointer + `ORX_LEN_SHORT;
                    if ((op[7:4] == 4'h7 && op[2:1] != 2'b00) || op == `ORX_OP_PUSH_AND_CALL_ABSOLUTE ||
                        (op == `ORX_PD_KEY_A && pd_key))
                        next_s.instruction_pointer = s.instruction_pointer + `ORX_LEN_LONG;
                    unique case (op)
                        `ORX_OP_NULL:
                            next_s.illegal = s.illegal || (b1 != `ORX_NULL_B1);
                        `ORX_OP_ORW_SHORT, `ORX_OP_ORB_SHORT:
                        begin
                            if (!b1[3])
                            begin
                                next_s.gpr = put_reg(s.gpr, dst_idx, bm, res_v);
                                next_s.psw = or_psw;
                            end
                            else
                            begin
                                next_s.mem     = '{s.gpr[{2'b00, b1[1:0]}], 16'h0000, 1'b0, bm};
                                next_s.mem_req = 1'b1;
                                next_s.st      = ST_SRC_RD;
                                if (b1[2])
                                    next_s.gpr[{2'b00, b1[1:0]}] = s.gpr[{2'b00, b1[1:0]}] +
                                        (bm ? `ORX_BYTE_STEP : `ORX_WORD_STEP);
                            end
                        end
                        `ORX_OP_ORW_RR, `ORX_OP_ORB_RR, `ORX_OP_ORW_IMM, `ORX_OP_ORB_IMM:
                        begin
                            next_s.gpr = put_reg(s.gpr, dst_idx, bm, res_v);
                            next_s.psw = or_psw;
                        end
                        `ORX_OP_ORW_REGMEM, `ORX_OP_ORB_REGMEM,
                        `ORX_OP_ORW_MEMREG, `ORX_OP_ORB_MEMREG:
                        begin
                            next_s.mem     = '{{b3, b2}, 16'h0000, 1'b0, bm};
                            next_s.mem_req = 1'b1;
                            next_s.st      = ST_SRC_RD;
                        end
                        `ORX_OP_PUSH_AND_CALL_ABSOLUTE, `ORX_OP_PUSH:
                        begin
                            next_s.stack_pointer = s.stack_pointer - `ORX_STACK_STEP;
                            next_s.mem     = '{s.stack_pointer - `ORX_STACK_STEP, src_v, 1'b1,
                                               1'b0};
                            next_s.mem_req = 1'b1;
                            next_s.psw     = {sw_e, sw_n, sw_z, s.psw[`ORX_PSW_V],
                                              s.psw[`ORX_PSW_C]};
                            next_s.st      = ST_PUSH_WR;
                        end
                        `ORX_OP_POP:
                        begin
                            next_s.mem     = '{s.stack_pointer, 16'h0000, 1'b0, 1'b0};
                            next_s.mem_req = 1'b1;
                            next_s.st      = ST_POP_RD;
                        end
                        `ORX_OP_NORM:
                        begin
                            next_s.gpr = put_reg(s.gpr, b1[7:4], 1'b0, norm_count(src_v));
                            next_s.psw = {1'b0, 1'b0, sw_z, 1'b0, 1'b0};
                        end
                        `ORX_PD_KEY_A:
                        begin
                            if (pd_key)
                            begin
                                if (!nmi_in)
                                    next_s.st = ST_DOWN;
                            end
                            else
                                next_s.illegal = 1'b1;
                        end
                        default:
                            next_s.illegal = 1'b1;
                    endcase
                end
            end
            ST_SRC_RD:
            begin
                if (mem_ack)
                begin
                    next_s.mem_req = 1'b0;
                    next_s.psw     = or_psw;
                    next_s.st      = ST_IDLE;
                    if (op[2:1] == 2'b10)
                    begin
                        next_s.mem.wdata = bm ? {res_v[7:0], res_v[7:0]} : res_v;
                        next_s.mem.we    = 1'b1;
                        next_s.mem_req   = 1'b1;
                        next_s.st        = ST_DST_WR;
                    end
                    else
                        next_s.gpr = put_reg(s.gpr, dst_idx, bm, res_v);
                end
            end
            ST_DST_WR:
            begin
                if (mem_ack)
                begin
                    next_s.mem_req = 1'b0;
                    next_s.st      = ST_IDLE;
                end
            end
            ST_PUSH_WR:
            begin
                if (mem_ack)
                begin
                    next_s.mem_req = 1'b0;
                    next_s.st      = ST_IDLE;
                    if (op == `ORX_OP_PUSH_AND_CALL_ABSOLUTE)
                    begin
                        next_s.stack_pointer = s.stack_pointer - `ORX_STACK_STEP;
                        next_s.mem     = '{s.stack_pointer - `ORX_STACK_STEP,
                                           s.instruction_pointer, 1'b1, 1'b0};
                        next_s.mem_req = 1'b1;
                        next_s.st      = ST_CALL_WR;
                    end
                end
            end
            ST_CALL_WR:
            begin
                if (mem_ack)
                begin
                    next_s.mem_req             = 1'b0;
                    next_s.instruction_pointer = {b3, b2};
                    next_s.st                  = ST_IDLE;
                end
            end
            ST_POP_RD:
            begin
                if (mem_ack)
                begin
                    next_s.mem_req       = 1'b0;
                    next_s.stack_pointer = s.stack_pointer + `ORX_STACK_STEP;
                    next_s.gpr           = put_reg(s.gpr, b1[3:0], 1'b0, mem_rdata);
                    next_s.psw           = {sw_e, sw_n, sw_z, s.psw[`ORX_PSW_V],
                                            s.psw[`ORX_PSW_C]};
                    next_s.st            = ST_IDLE;
                end
            end
            ST_DOWN:
                next_s.st = ST_DOWN;
        endcase
    end

    // =========================================================
    // registers
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            s                     <= '0;
            s.st                  <= ST_IDLE;
            s.stack_pointer       <= `ORX_RST_SP;
            s.instruction_pointer <= `ORX_RST_IP;
            s.psw                 <= `ORX_RST_PSW;
        end
        else if (ce)
            s <= next_s;
    end

    // =========================================================
    // outputs
    assign wb_ack              = s.wb_ack;
    assign wb_dat_r            = s.wb_dat;
    assign instruction_pointer = s.instruction_pointer;
    assign mem                 = s.mem;
    assign mem_req             = s.mem_req;
    assign power_down          = (s.st == ST_DOWN);
    assign psw                 = s.psw;

endmodule // orx_exec

// ===== orx_mem_model.sv
`timescale 1ns/100ps
module orx_mem_model
    import orx_pkg::*;
(
    // memory port
    input  wire logic       sys_clk,
    input  wire orx_mem_s   mem,
    input  wire logic       mem_req,
    input  wire logic [1:0] wait_n,
    output logic            mem_ack,
    output logic [15:0]     mem_rdata
);
    // ==========================================
    // word store, answer after wait_n cycles
    logic [15:0] ram [0:255];
    logic [1:0]  cnt = 2'h0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 16'h0000;
    always @(posedge sys_clk)
    begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && cnt == wait_n)
        begin
            mem_ack <= 1'b1;
            cnt     <= 2'h0;
            if (mem.we)
                ram[mem.addr[8:1]] <= mem.wdata;
            else
                mem_rdata <= ram[mem.addr[8:1]];
        end
        else if (mem_req && !mem_ack)
            cnt <= cnt + 2'h1;
    end
endmodule // orx_mem_model

// ===== orx_exec_monitor.sv
`timescale 1ns/100ps
module orx_exec_monitor
    import orx_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        ce,
    // instruction fetch
    input wire logic        instr_valid,
    input wire logic [31:0] instr_data,
    input wire logic        instr_ready,
    input wire logic [15:0] instruction_pointer,
    // memory and system
    input wire orx_mem_s    mem,
    input wire logic        mem_req,
    input wire logic        nmi_in,
    input wire logic        power_down,
    input wire logic [4:0]  psw
);
    logic        acc;
    logic [15:0] tgt;
    assign acc = ce && instr_valid && instr_ready;
    always_ff @(posedge sys_clk)
        if (acc && instr_data[7:0] == 8'hE2)
            tgt <= instr_data[31:16];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ==========================================
    // properties
    sequence s_pd_acc;
        acc && instr_data == 32'h9797_6897;
    endsequence
    sequence s_push_and_call_absolute_acc;
        acc && instr_data[7:0] == 8'hE2;
    endsequence
    property p_null;
        acc && instr_data[15:0] == 16'h00CC |=> psw == $past(psw) && !mem_req;
    endproperty
    a_null: assert property (p_null) else $error("null changed state");
    property p_or_flags;
        acc && instr_data[7:0] == 8'h70 |=> psw[1:0] == 2'b00
            && instruction_pointer == $past(instruction_pointer) + 16'h0002;
    endproperty
    a_or_flags: assert property (p_or_flags) else $error("or flags");
    property p_norm_flags;
        acc && instr_data[7:0] == 8'h2B |=> psw[4:3] == 2'b00 && psw[1:0] == 2'b00;
    endproperty
    a_norm_flags: assert property (p_norm_flags) else $error("normalize flags");
    property p_push;
        acc && instr_data[7:0] == 8'hEC |=> mem_req && mem.we
            && psw[1:0] == $past(psw[1:0]) && psw[4] == (mem.wdata == 16'h8000)
            && psw[2] == (mem.wdata == 16'h0000) && psw[3] == mem.wdata[15];
    endproperty
    a_push: assert property (p_push) else $error("push write or flags");
    property p_push_and_call_absolute;
        s_push_and_call_absolute_acc |-> ##[3:100] (instr_ready && instruction_pointer == tgt);
    endproperty
    a_push_and_call_absolute: assert property (p_push_and_call_absolute) else $error("call target missed");
    property p_pd_on;
        s_pd_acc ##0 !nmi_in |=> power_down;
    endproperty
    a_pd_on: assert property (p_pd_on) else $error("no power down");
    property p_pd_nmi;
        s_pd_acc ##0 nmi_in |=> !power_down
            && instruction_pointer == $past(instruction_pointer) + 16'h0004;
    endproperty
    a_pd_nmi: assert property (p_pd_nmi) else $error("power down with nmi");
    property p_pd_hold;
        power_down |=> power_down && !instr_ready && $stable(psw);
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power down left");
    property p_pd_guard;
        acc && instr_data[7:0] == 8'h97 && instr_data[31:8] != 24'h979768 |=> !power_down;
    endproperty
    a_pd_guard: assert property (p_pd_guard) else $error("partial pattern");
endmodule // orx_exec_monitor

bind orx_exec orx_exec_monitor u_mon (.sys_clk, .reset, .ce, .instr_valid, .instr_data,
    .instr_ready, .instruction_pointer, .mem, .mem_req, .nmi_in, .power_down, .psw);

// ===== test_or_stack_normalize_count_instr_power_down_instr_exec.sv
`timescale 1ns/100ps
module test_or_stack_normalize_count_instr_power_down_instr_exec
    import orx_pkg::*;
;
    logic        sys_clk = 1'b0, reset = 1'b1, ce = 1'b1, instr_valid = 1'b0, nmi_in = 1'b0;
    logic        wb_ack, instr_ready, mem_req, mem_ack, power_down;
    logic [31:0] wb_dat_r, instr_data;
    logic [15:0] instruction_pointer, mem_rdata, q, ip0;
    logic [4:0]  psw;
    logic [1:0]  wait_n;
    orx_wb_req_s wb_req;
    orx_mem_s    mem;
    int          n_errors = 0, comparisons = 0;
    orx_exec dut (.sys_clk, .reset, .ce, .wb_req, .wb_ack, .wb_dat_r, .instr_valid,
        .instr_data, .instr_ready, .instruction_pointer, .mem, .mem_req, .mem_ack,
        .mem_rdata, .nmi_in, .power_down, .psw);
    orx_mem_model mm (.sys_clk, .mem, .mem_req, .wait_n, .mem_ack, .mem_rdata);
    always #25 sys_clk = ~sys_clk;
    // ==========================================
    // access tasks
    task wb(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
        @(posedge sys_clk);
        wb_req <= '{1'b1, 1'b1, we, a, 4'h3, {16'h0000, d}};
        do @(posedge sys_clk); while (wb_ack !== 1'b1);
        r = wb_dat_r[15:0];
        wb_req <= '0;
    endtask
    task run(input logic [31:0] d);
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr_data  <= d;
        do @(posedge sys_clk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
    endtask
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000, q);
        cmp(nm, e, q);
    endtask
    task close_out;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // tests
    initial
    begin
        wb_req = '0;
        instr_data = 32'h0000_0000;
        wait_n = 2'h0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        wb(1'b1, 8'h04, 16'h8000, q);
        wb(1'b1, 8'h08, 16'h0101, q);
        wb(1'b1, 8'h1C, 16'hFFFF, q);
        wb(1'b1, 8'h40, 16'h0040, q);
        run(32'h0000_2170);
        rchk("r2", 8'h08, 16'h8101);
        rchk("psw", 8'h48, 16'h0018);
        run(32'h0000_00CC);
        rchk("psw", 8'h48, 16'h0018);
        rchk("unmapped", 8'h80, 16'h0000);
        run(32'h0000_3578);
        rchk("r3", 8'h0C, 16'h0005);
        run(32'h0000_4679);
        run(32'hAA80_F577);
        rchk("r2", 8'h08, 16'h8107);
        rchk("psw", 8'h48, 16'h0018);
        run(32'h0000_432B);
        rchk("r4", 8'h10, 16'h000D);
        run(32'h0000_762B);
        rchk("r7", 8'h1C, 16'h0000);
        rchk("psw", 8'h48, 16'h0004);
        wb(1'b1, 8'h48, 16'h0003, q);
        run(32'h0000_F1EC);
        rchk("sp", 8'h40, 16'h003E);
        rchk("psw", 8'h48, 16'h001B);
        cmp("stack", 16'h8000, mm.ram[8'h1F]);
        wb(1'b1, 8'h48, 16'h0004, q);
        run(32'h0000_F8FC);
        rchk("r8", 8'h20, 16'h8000);
        rchk("sp", 8'h40, 16'h0040);
        rchk("psw", 8'h48, 16'h0018);
        wb(1'b0, 8'h44, 16'h0000, ip0);
        wait_n <= 2'h2;
        run(32'h1234_F2E2);
        rchk("ip", 8'h44, 16'h1234);
        rchk("sp", 8'h40, 16'h003C);
        cmp("operand", 16'h8107, mm.ram[8'h1F]);
        cmp("return", ip0 + 16'h0004, mm.ram[8'h1E]);
        rchk("psw", 8'h48, 16'h0008);
        run(32'h9697_6897);
        nmi_in <= 1'b1;
        run(32'h9797_6897);
        rchk("ip", 8'h44, 16'h123A);
        nmi_in <= 1'b0;
        run(32'h9797_6897);
        repeat (2) @(posedge sys_clk);
        cmp("down", 16'h0001, {15'h0000, power_down});
        cmp("flags", 16'h0008, {11'h000, psw});
        reset <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        cmp("wake", 16'h0000, {15'h0000, power_down});
        close_out;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        close_out;
    end
endmodule // test_or_stack_normalize_count_instr_power_down_instr_exec
